// ### common/pmx_pkg.sv
// constants for the port and lcd pin multiplexer
// assumes a single 250 MHz clock domain
package pmx_pkg;
  // per-line mode encoding
  localparam logic [2:0] MODE_IN_FLOAT = 3'h0;
  localparam logic [2:0] MODE_IN_PULLUP = 3'h1;
  localparam logic [2:0] MODE_IN_IRQ = 3'h2;
  localparam logic [2:0] MODE_OUT_OD = 3'h3;
  localparam logic [2:0] MODE_OUT_PP = 3'h4;
  localparam logic [2:0] MODE_ANALOG = 3'h5;
  localparam int LINES = 4;
  localparam int SHARED = 8;
  localparam int COMMONS = 8;
  // line indices of port a alternate functions (port a lines 4..7 -> 0..3)
  localparam int TIMER_BIT = 0;
  localparam int SCK_BIT = 1;
  localparam int SDI_BIT = 2;
  localparam int SDO_BIT = 3;
  localparam logic [2:0] RESET_MODE = 3'h0;
  localparam logic RESET_SYNC = 1'b1;
endpackage

// ### rtl/pmx_pin_mux.sv
// pin multiplexer for three 4-line ports, lcd common/segment lines and system pins
// assumes pads resolve wires from o_*_out and o_*_oe; pulls are modelled by o_*_pu enables
`timescale 1ns/1ps
// How it works
// - port a lines select float, pull-up, interrupt, open-drain or push-pull mode.
// - port b lines add an analog mode feeding the converter.
// - port c lines likewise offer analog converter input mode.
// - port a lines five to seven carry serial clock, data in, data out.
// - timer line in input mode feeds the timer prescaler input.
// - timer line in output mode drives the timer output bit.
// - eight common lines always come from the backplane generator.
// - shared lines act as eight commons or eight segments as a group.
// - nmi pin synchronised, falling edge raises top interrupt; idles high.
// - low reset pin restarts the core; pin idles high.
// - test pin low means normal mode; pull-down when floating.
module pmx_pin_mux (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [11:0] i_pa_mode,
  input wire logic [11:0] i_pb_mode,
  input wire logic [11:0] i_pc_mode,
  input wire logic [3:0] i_pa_data,
  input wire logic [3:0] i_pb_data,
  input wire logic [3:0] i_pc_data,
  input wire logic [3:0] i_pa_pin,
  input wire logic [3:0] i_pb_pin,
  input wire logic [3:0] i_pc_pin,
  output logic [3:0] o_pa_out,
  output logic [3:0] o_pa_oe,
  output logic [3:0] o_pa_pu,
  output logic [3:0] o_pb_out,
  output logic [3:0] o_pb_oe,
  output logic [3:0] o_pb_pu,
  output logic [3:0] o_pc_out,
  output logic [3:0] o_pc_oe,
  output logic [3:0] o_pc_pu,
  output logic [3:0] o_pa_in,
  output logic [3:0] o_pb_in,
  output logic [3:0] o_pc_in,
  output logic [3:0] o_port_irq,
  output logic [3:0] o_pb_analog_en,
  output logic [3:0] o_pc_analog_en,
  input wire logic i_serial_clock_out,
  input wire logic i_serial_clock_oe,
  input wire logic i_serial_data_out,
  input wire logic i_serial_data_out_en,
  output logic o_serial_clock_in,
  output logic o_serial_data_in,
  input wire logic i_timer_out_bit,
  input wire logic i_timer_timeout,
  output logic o_timer_in,
  input wire logic [7:0] i_backplane_drive,
  input wire logic [7:0] i_shared_common_drive,
  input wire logic [7:0] i_shared_segment_drive,
  input wire logic i_shared_as_common,
  output logic [7:0] o_lcd_common_lines,
  output logic [7:0] o_shared_common_segment_lines,
  input wire logic i_nmi_pin,
  output logic o_nmi_req,
  output logic o_nmi_pu,
  input wire logic i_reset_pin_b,
  output logic o_core_rst_b,
  output logic o_reset_pu,
  input wire logic i_test_pin,
  output logic o_test_mode,
  output logic o_test_pd
);
  logic [11:0] pin_raw;
  logic [11:0] s1_r, s2_r, s3_r, clean_r;
  logic [11:0] clean_prev_r;
  logic [35:0] mode_all;
  logic [11:0] data_all, out_all, oe_all, pu_all, irq_all, ana_all;
  logic timer_q_r;
  logic [2:0] nmi_s_r, rst_s_r, tst_s_r;
  logic nmi_clean_r, rst_clean_r, tst_clean_r;
  logic nmi_prev_r;

  assign pin_raw = {i_pc_pin, i_pb_pin, i_pa_pin};
  assign mode_all = {i_pc_mode, i_pb_mode, i_pa_mode};
  assign data_all = {i_pc_data, i_pb_data, i_pa_data};

  // three-stage synchroniser; change accepted once stages two and three agree
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_r <= 12'h000;
      s2_r <= 12'h000;
      s3_r <= 12'h000;
      clean_r <= 12'h000;
      clean_prev_r <= 12'h000;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      clean_r <= (s2_r & s3_r) | (clean_r & (s2_r ^ s3_r)) | (clean_r & ~(s2_r ^ s3_r) & s2_r);
      clean_prev_r <= clean_r;
    end
  end

  // timer output bit is latched on each time-out
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      timer_q_r <= 1'b0;
    end else if (i_timer_timeout) begin
      timer_q_r <= i_timer_out_bit;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 12; g++) begin : g_line
      logic [2:0] m;
      logic ana_ok, drv;
      assign m = mode_all[3*g +: 3];
      // port a has no analog mode; treat that code as plain input
      assign ana_ok = (g >= 4) && (m == pmx_pkg::MODE_ANALOG);
      assign ana_all[g] = ana_ok;
      // alternate functions override port data on port a lines
      assign drv = (g == pmx_pkg::TIMER_BIT) ? timer_q_r :
                   (g == pmx_pkg::SCK_BIT && i_serial_clock_oe) ? i_serial_clock_out :
                   (g == pmx_pkg::SDO_BIT && i_serial_data_out_en) ? i_serial_data_out :
                   data_all[g];
      // open-drain only drives low, push-pull drives both levels
      assign oe_all[g] = (m == pmx_pkg::MODE_OUT_PP) || ((m == pmx_pkg::MODE_OUT_OD) && !drv);
      assign out_all[g] = (m == pmx_pkg::MODE_OUT_PP) ? drv : 1'b0;
      assign pu_all[g] = (m == pmx_pkg::MODE_IN_PULLUP) || (m == pmx_pkg::MODE_IN_IRQ);
      // interrupt input flags a falling edge of the filtered level
      assign irq_all[g] = (m == pmx_pkg::MODE_IN_IRQ) && clean_prev_r[g] && !clean_r[g];
    end
  endgenerate

  assign o_pa_out = out_all[3:0];
  assign o_pb_out = out_all[7:4];
  assign o_pc_out = out_all[11:8];
  assign o_pa_oe = oe_all[3:0];
  assign o_pb_oe = oe_all[7:4];
  assign o_pc_oe = oe_all[11:8];
  assign o_pa_pu = pu_all[3:0];
  assign o_pb_pu = pu_all[7:4];
  assign o_pc_pu = pu_all[11:8];
  // analog lines read as zero so the digital path does not toggle
  assign o_pa_in = clean_r[3:0];
  assign o_pb_in = clean_r[7:4] & ~ana_all[7:4];
  assign o_pc_in = clean_r[11:8] & ~ana_all[11:8];
  assign o_pb_analog_en = ana_all[7:4];
  assign o_pc_analog_en = ana_all[11:8];
  assign o_port_irq = {|irq_all[11:8], |irq_all[7:4], |irq_all[3:0], 1'b0};
  assign o_serial_clock_in = clean_r[pmx_pkg::SCK_BIT];
  assign o_serial_data_in = clean_r[pmx_pkg::SDI_BIT];
  // timer input only when the line is an input mode
  assign o_timer_in = (i_pa_mode[2:0] <= pmx_pkg::MODE_IN_IRQ) ? clean_r[pmx_pkg::TIMER_BIT] : 1'b0;

  assign o_lcd_common_lines = i_backplane_drive;
  assign o_shared_common_segment_lines = i_shared_as_common ? i_shared_common_drive : i_shared_segment_drive;

  // system pins share the same synchroniser style
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      nmi_s_r <= 3'h7;
      rst_s_r <= 3'h7;
      tst_s_r <= 3'h0;
      nmi_clean_r <= pmx_pkg::RESET_SYNC;
      rst_clean_r <= pmx_pkg::RESET_SYNC;
      tst_clean_r <= 1'b0;
      nmi_prev_r <= 1'b1;
    end else begin
      nmi_s_r <= {nmi_s_r[1:0], i_nmi_pin};
      rst_s_r <= {rst_s_r[1:0], i_reset_pin_b};
      tst_s_r <= {tst_s_r[1:0], i_test_pin};
      if (nmi_s_r[1] == nmi_s_r[2]) nmi_clean_r <= nmi_s_r[1];
      if (rst_s_r[1] == rst_s_r[2]) rst_clean_r <= rst_s_r[1];
      if (tst_s_r[1] == tst_s_r[2]) tst_clean_r <= tst_s_r[1];
      nmi_prev_r <= nmi_clean_r;
    end
  end

  assign o_nmi_req = nmi_prev_r && !nmi_clean_r;
  assign o_nmi_pu = 1'b1;
  assign o_core_rst_b = rst_clean_r;
  assign o_reset_pu = 1'b1;
  assign o_test_mode = tst_clean_r;
  assign o_test_pd = 1'b1;

  nmi_edge_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    $fell(nmi_clean_r) |-> o_nmi_req ##1 !o_nmi_req) else $error("nmi edge missed");
  rst_follow_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (rst_s_r[1] == rst_s_r[2]) |=> (o_core_rst_b == $past(rst_s_r[1]))) else $error("reset not followed");
  test_mode_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (tst_s_r[2:1] == 2'b00) |=> !o_test_mode) else $error("test mode wrong");
  pullup_mode_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_pa_mode[2:0] >= pmx_pkg::MODE_OUT_OD) |-> !o_pa_pu[0]) else $error("pull-up in output");
  common_drive_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    o_lcd_common_lines == i_backplane_drive) else $error("common not backplane");
  shared_sel_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !i_shared_as_common |-> o_shared_common_segment_lines == i_shared_segment_drive) else $error("segment sel");
  timer_out_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_timer_timeout && i_pa_mode[2:0] == pmx_pkg::MODE_OUT_PP) |=> o_pa_out[0] == $past(i_timer_out_bit))
    else $error("timer out wrong");
  analog_b_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_pb_mode[2:0] == pmx_pkg::MODE_ANALOG) |-> o_pb_analog_en[0] && !o_pb_in[0] && !o_pb_oe[0])
    else $error("analog b wrong");
  analog_c_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_pc_mode[2:0] == pmx_pkg::MODE_ANALOG) |-> o_pc_analog_en[0] && !o_pc_pu[0]) else $error("analog c");
  sdo_route_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_serial_data_out_en && i_pa_mode[11:9] == pmx_pkg::MODE_OUT_PP) |-> o_pa_out[3] == i_serial_data_out)
    else $error("serial out route");
  od_drive_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_pa_mode[5:3] == pmx_pkg::MODE_OUT_OD) |-> !o_pa_out[1]) else $error("open drain high");
  timer_in_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_pa_mode[2:0] == pmx_pkg::MODE_IN_FLOAT) |-> o_timer_in == o_pa_in[0]) else $error("timer in");
endmodule // pmx_pin_mux

// ### tb/pmx_board.sv
// board model of one 4-line port: pad level from device drive, board source and pull
// assumes the board never fights a driving line; the device drive wins
`timescale 1ns/1ps
module pmx_board (
  input wire logic i_mclk,
  input wire logic [3:0] i_out,
  input wire logic [3:0] i_oe,
  input wire logic [3:0] i_pu,
  input wire logic [3:0] i_ext,
  input wire logic [3:0] i_ext_en,
  output logic [3:0] o_pin
);
  logic flt_r = 1'b0;
  // an undriven unpulled line toggles every clock, so the filter never accepts it and keeps its last level
  always @(posedge i_mclk) flt_r <= ~flt_r;
  assign o_pin = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext) | (~i_oe & ~i_ext_en & (i_pu | {4{flt_r}}));
endmodule // pmx_board

// ### tb/tb.sv
// self-checking bench for the pin multiplexer
// assumes pmx_board models the pads of all three ports
`timescale 1ns/1ps
module tb;
  logic i_mclk = 1'b0, i_rst_b = 1'b0;
  logic [11:0] i_pa_mode = '0, i_pb_mode = '0, i_pc_mode = '0;
  logic [3:0] i_pa_data = '0, i_pb_data = '0, i_pc_data = '0;
  logic [3:0] ext_a = '0, ext_b = '0, ext_c = '0, en_a = '0, en_b = '0, en_c = '0;
  wire [3:0] i_pa_pin, i_pb_pin, i_pc_pin;
  logic i_serial_clock_out = 0, i_serial_clock_oe = 0, i_serial_data_out = 0, i_serial_data_out_en = 0;
  logic i_timer_out_bit = 0, i_timer_timeout = 0, i_shared_as_common = 0;
  logic i_nmi_pin = 1, i_reset_pin_b = 1, i_test_pin = 0;
  logic [7:0] i_backplane_drive = '0, i_shared_common_drive = '0, i_shared_segment_drive = '0;
  logic [3:0] o_pa_out, o_pa_oe, o_pa_pu, o_pb_out, o_pb_oe, o_pb_pu, o_pc_out, o_pc_oe, o_pc_pu;
  logic [3:0] o_pa_in, o_pb_in, o_pc_in, o_port_irq, o_pb_analog_en, o_pc_analog_en;
  logic o_serial_clock_in, o_serial_data_in, o_timer_in, o_nmi_req, o_nmi_pu;
  logic o_core_rst_b, o_reset_pu, o_test_mode, o_test_pd;
  logic [7:0] o_lcd_common_lines, o_shared_common_segment_lines;
  logic [7:0] nmi_n = '0, irqb_n = '0, irqc_n = '0;
  int failures = 0;
  int cmp_count = 0;
  pmx_pin_mux uut (.*);
  pmx_board brd_a (.i_mclk(i_mclk), .i_out(o_pa_out), .i_oe(o_pa_oe), .i_pu(o_pa_pu), .i_ext(ext_a), .i_ext_en(en_a), .o_pin(i_pa_pin));
  pmx_board brd_b (.i_mclk(i_mclk), .i_out(o_pb_out), .i_oe(o_pb_oe), .i_pu(o_pb_pu), .i_ext(ext_b), .i_ext_en(en_b), .o_pin(i_pb_pin));
  pmx_board brd_c (.i_mclk(i_mclk), .i_out(o_pc_out), .i_oe(o_pc_oe), .i_pu(o_pc_pu), .i_ext(ext_c), .i_ext_en(en_c), .o_pin(i_pc_pin));
  always #2 i_mclk = ~i_mclk;
  // pulse counters let a one-cycle pulse be judged after the fact
  always @(posedge i_mclk) begin
    nmi_n <= nmi_n + {7'h0, o_nmi_req};
    irqb_n <= irqb_n + {7'h0, o_port_irq[2]};
    irqc_n <= irqc_n + {7'h0, o_port_irq[3]};
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic t_modes();
    logic [2:0] m;
    logic [7:0] oe, pu;
    for (int k = 0; k < 6; k++) begin
      m = k[2:0];
      oe = {8{m == 3'h3 || m == 3'h4}};
      pu = {8{m == 3'h1 || m == 3'h2}};
      @(posedge i_mclk);
      {i_pa_mode, i_pb_mode, i_pc_mode} <= {12{m}};
      {i_pa_data, i_pb_data, i_pc_data} <= {12{m == 3'h4}};
      {ext_b, en_b} <= 8'hff;
      cyc(5);
      chk({o_pb_oe, o_pc_oe}, oe, "oe b c");
      chk({o_pb_pu, o_pc_pu}, pu, "pull b c");
      chk({o_pb_analog_en, o_pc_analog_en}, {8{m == 3'h5}}, "analog");
      if (m < 3'h5) chk({5'h0, o_pa_oe[3:1]}, {5'h0, oe[2:0]}, "oe a");
      if (m < 3'h5) chk({5'h0, o_pa_pu[3:1]}, {5'h0, pu[2:0]}, "pull a");
      if (oe[0]) chk({o_pb_out, o_pc_out}, {8{m == 3'h4}}, "drive");
      if (!oe[0]) chk({4'h0, o_pb_in}, {4'h0, {4{m != 3'h5}}}, "in b");
    end
    $display("modes done");
  endtask
  task automatic t_irq();
    logic [7:0] b0, c0;
    @(posedge i_mclk);
    {i_pb_mode, i_pc_mode} <= {{4{3'h2}}, {4{3'h1}}};
    {ext_c, en_c} <= 8'hff;
    cyc(6);
    b0 = irqb_n;
    c0 = irqc_n;
    @(posedge i_mclk);
    {ext_b, ext_c} <= 8'h00;
    cyc(2);
    chk({4'h0, o_pb_in}, 8'h0f, "early fall");
    cyc(6);
    chk(irqb_n - b0, 8'h01, "irq count");
    chk(irqc_n - c0, 8'h00, "irq off mode");
    chk({4'h0, o_pc_in}, 8'h00, "in c");
    $display("irq done");
  endtask
  task automatic t_alt();
    @(posedge i_mclk);
    i_pa_mode <= {3'h4, 3'h0, 3'h4, 3'h0};
    i_pa_data <= 4'h5;
    {i_serial_clock_oe, i_serial_clock_out, i_serial_data_out_en, i_serial_data_out} <= 4'b1110;
    {ext_a, en_a} <= 8'h55;
    cyc(6);
    chk({6'h0, o_pa_out[3], o_pa_out[1]}, 8'h01, "serial out");
    chk({6'h0, o_serial_data_in, o_timer_in}, 8'h03, "alt in");
    chk({7'h0, o_serial_clock_in}, 8'h01, "serial clock in");
    @(posedge i_mclk);
    i_pa_mode[2:0] <= 3'h3;
    {i_timer_out_bit, i_timer_timeout} <= 2'b11;
    @(posedge i_mclk);
    i_timer_timeout <= 1'b0;
    cyc(2);
    chk({6'h0, o_pa_oe[0], o_timer_in}, 8'h00, "timer one");
    @(posedge i_mclk);
    {i_timer_out_bit, i_timer_timeout} <= 2'b01;
    @(posedge i_mclk);
    i_timer_timeout <= 1'b0;
    cyc(2);
    chk({6'h0, o_pa_oe[0], o_pa_out[0]}, 8'h02, "timer zero");
    $display("alternate done");
  endtask
  task automatic t_sys();
    logic [7:0] n0;
    @(posedge i_mclk);
    {i_backplane_drive, i_shared_common_drive, i_shared_segment_drive} <= 24'h5a3cc3;
    i_shared_as_common <= 1'b1;
    cyc(1);
    chk(o_lcd_common_lines, 8'h5a, "commons");
    chk(o_shared_common_segment_lines, 8'h3c, "shared com");
    @(posedge i_mclk);
    i_shared_as_common <= 1'b0;
    n0 = nmi_n;
    i_nmi_pin <= 1'b0;
    {i_reset_pin_b, i_test_pin} <= 2'b01;
    cyc(8);
    chk(o_shared_common_segment_lines, 8'hc3, "shared seg");
    chk(nmi_n - n0, 8'h01, "nmi count");
    chk({6'h0, o_core_rst_b, o_test_mode}, 8'h01, "sys pins");
    $display("system done");
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // software duties on bits and memory outside this block; nothing here can break them
  initial begin
    cyc(2);
    chk({4'h0, o_nmi_pu, o_reset_pu, o_test_pd, o_nmi_req}, 8'h0e, "pulls");
    chk({6'h0, o_core_rst_b, o_test_mode}, 8'h02, "reset state");
    repeat (6) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    t_modes();
    t_irq();
    t_alt();
    t_sys();
    close_out();
  end
  initial begin
    #100000;
    failures++;
    close_out();
  end
endmodule // tb
